/* File: icr_cfg_monitor.sv */
/*
 * Port checker for the channel fourteen reference configuration block.
 * Assumes it is bound to icr_channel_cfg and sees only its ports.
 */
`timescale 1ns/1ps
`include "icr_map.vh"
module icr_cfg_monitor (
  input wire clk, // clock
  input wire rst_b, // reset
  input wire [7:0] avs_address, // bus
  input wire avs_read, // bus
  input wire avs_write, // bus
  input wire [31:0] avs_writedata, // bus
  input wire [3:0] avs_byteenable, // bus
  input wire [31:0] avs_readdata, // bus
  input wire avs_waitrequest, // bus
  input wire dpll_clk, // route
  input wire monitor_clk, // route
  input wire prog_div_select, // status
  input wire preset_eight_khz_select, // status
  input wire [1:0] activity_profile_select, // status
  input wire [3:0] freq_code, // status
  input wire [17:0] nominal_khz, // decode
  input wire freq_code_valid // decode
);
  wire [7:0] st = {prog_div_select, preset_eight_khz_select,
    activity_profile_select, freq_code};
  wire [7:0] wd = avs_writedata[7:0];
  wire req = avs_read | avs_write;
  wire hit = avs_address == `ICR_CFG_ADDR;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wait_pulse_a:
    assert property (req && avs_waitrequest |=>
      !avs_waitrequest ##1 avs_waitrequest) else $error("bad answer");
  wr_apply_a:
    assert property (avs_write && !avs_waitrequest && hit &&
      avs_byteenable[0] |-> ##2 st == $past(wd, 2))
      else $error("write not applied");
  rd_data_a:
    assert property (avs_read && !avs_waitrequest && hit |->
      avs_readdata == {24'h000000, st}) else $error("bad read data");
  unmapped_rd_a:
    assert property (avs_read && !avs_waitrequest && !hit |->
      avs_readdata == 32'h00000000) else $error("unmapped read");
  reset_val_a:
    assert property ($rose(rst_b) |-> st == `ICR_CFG_RESET &&
      avs_waitrequest) else $error("bad reset value");
  code_top_a:
    assert property (freq_code == 4'h8 && $stable(freq_code) |->
      nominal_khz == `ICR_KHZ_155M52 && freq_code_valid)
      else $error("bad decode");
  prog_route_a:
    assert property (prog_div_select [*3] |-> dpll_clk == monitor_clk)
      else $error("paths differ");
  direct_route_a:
    assert property ((!prog_div_select && !preset_eight_khz_select) [*3]
      |-> dpll_clk == monitor_clk) else $error("direct paths differ");
endmodule

bind icr_channel_cfg icr_cfg_monitor u_mon (.clk(clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .dpll_clk(dpll_clk), .monitor_clk(monitor_clk),
  .prog_div_select(prog_div_select),
  .preset_eight_khz_select(preset_eight_khz_select),
  .activity_profile_select(activity_profile_select),
  .freq_code(freq_code), .nominal_khz(nominal_khz),
  .freq_code_valid(freq_code_valid));

/* File: icr_channel_cfg.v */
/*
 * Channel fourteen reference configuration register with its clock
 * routing, preset and programmable pre-dividers, frequency decode and
 * a leaky-bucket activity monitor.
 * Assumes input_channel_fourteen is asynchronous and much slower than clk; the
 * programmable ratio and rate select come from clk-domain registers.
 */
// Functional notes
// R1 - divider bit clear feeds channel straight on; set routes via programmable divider
// R2 - preset bit set divides channel to 8 kHz before DPLL; clear feeds direct
// R3 - preset 8 kHz bit ignored while programmable divider bit is set
// R4 - channel keeps its own leaky-bucket accumulator for activity monitoring
// R5 - bits 5:4 pick one of four leaky-bucket configurations
// R6 - bits 3:0 declare nominal reference frequency per code table
// R7 - code 0001 means 1544 or 2048 kHz by rate select input
// R8 - code 1001 is 2 kHz, 1010 is 4 kHz, other codes unused
// R9 - software should set frequency code 0000 when programmable divider used
// R10 - register reads 0x01 after reset
// R11 - writes act at once on routing and profile; reads return last write
`timescale 1ns/1ps
`include "icr_map.vh"
module icr_channel_cfg (
  input wire clk,                     // 125 MHz system clock
  input wire rst_b,                   // sync reset, active low
  input wire [7:0] avs_address,       // byte address
  input wire avs_read,                // read request
  input wire avs_write,               // write request
  input wire [31:0] avs_writedata,    // write data
  input wire [3:0] avs_byteenable,    // byte lanes
  output reg [31:0] avs_readdata,     // read data
  output reg avs_waitrequest,         // stall
  input wire input_channel_fourteen,  // reference clock pin
  input wire sonet_sdh_rate_select,   // 1: 1544 kHz, 0: 2048 kHz
  input wire [13:0] prog_div_ratio,   // programmable divider ratio
  input wire [31:0] bucket_limit_cfg, // four 8-bit bucket limits
  output reg dpll_clk,                // clock towards DPLL
  output reg monitor_clk,             // clock towards freq monitor
  output reg prog_div_select,         // programmable path in use
  output reg preset_eight_khz_select, // preset 8 kHz bit as stored
  output reg [1:0] activity_profile_select, // bucket profile
  output reg [3:0] freq_code,         // nominal frequency code
  output reg [17:0] nominal_khz,      // decoded frequency, kHz
  output reg freq_code_valid,         // code is a defined one
  output reg [7:0] bucket_level,      // accumulator level
  output reg activity_alarm           // bucket at or over limit
);

  reg [7:0] cfg_r;
  reg [7:0] cfg_nxt;
  reg sync1_r;
  reg sync2_r;
  reg sync3_r;
  wire ref_edge;
  wire prog_div_out;
  wire preset_div_out;
  reg [15:0] preset_ratio;
  wire [15:0] prog_ratio16;
  reg [17:0] khz_nxt;
  reg khz_ok;
  reg [15:0] win_cnt_r;
  reg edge_seen_r;
  reg [7:0] acc_r;
  reg [7:0] acc_nxt;
  reg [7:0] limit_sel;
  wire bus_req;
  wire addr_hit;
  wire cfg_prog;
  wire cfg_preset;
  wire [1:0] cfg_prof;
  wire [3:0] cfg_freq;
  wire preset_bypass;
  wire win_end;

  assign cfg_prog = cfg_r[`ICR_BIT_PROG_DIV];
  assign cfg_preset = cfg_r[`ICR_BIT_PRESET_8K];
  assign cfg_prof = cfg_r[`ICR_PROF_HI:`ICR_PROF_LO];
  assign cfg_freq = cfg_r[`ICR_FREQ_HI:`ICR_FREQ_LO];

  // bus slave: one wait cycle, then the access completes
  assign bus_req = avs_read | avs_write;
  assign addr_hit = (avs_address == `ICR_CFG_ADDR);

  always @* begin
    cfg_nxt = cfg_r;
    // byte lane 0 carries the whole register
    if (avs_write && !avs_waitrequest && addr_hit && avs_byteenable[0])
      cfg_nxt = avs_writedata[7:0]; // R11
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      cfg_r <= `ICR_CFG_RESET; // R10
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      cfg_r <= cfg_nxt;
      if (bus_req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        // unmapped addresses read as zero, writes to them are dropped
        if (avs_read && addr_hit)
          avs_readdata <= {24'h00_0000, cfg_r}; // R11
        else
          avs_readdata <= 32'h0000_0000;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // pin synchroniser; the second and third stages feed the edge detector
  always @(posedge clk) begin
    if (!rst_b) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= input_channel_fourteen;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign ref_edge = sync2_r & ~sync3_r;

  // preset ratio follows the declared frequency
  always @* begin
    case (cfg_freq)
      `ICR_FC_T1E1: begin
        if (sonet_sdh_rate_select)
          preset_ratio = `ICR_DIV_1544; // R7
        else
          preset_ratio = `ICR_DIV_2048; // R7
      end
      `ICR_FC_6M48: preset_ratio = `ICR_DIV_6M48;
      `ICR_FC_19M44: preset_ratio = `ICR_DIV_19M44;
      `ICR_FC_25M92: preset_ratio = `ICR_DIV_25M92;
      `ICR_FC_38M88: preset_ratio = `ICR_DIV_38M88;
      `ICR_FC_51M84: preset_ratio = `ICR_DIV_51M84;
      `ICR_FC_77M76: preset_ratio = `ICR_DIV_77M76;
      `ICR_FC_155M52: preset_ratio = `ICR_DIV_155M52;
      // 8 kHz and slower cannot be brought down to 8 kHz; passed on
      default: preset_ratio = `ICR_DIV_BYPASS; // R8
    endcase
  end

  assign preset_bypass = (preset_ratio == `ICR_DIV_BYPASS);
  assign prog_ratio16 = {2'b00, prog_div_ratio};

  // both dividers always run; a newly chosen path starts mid-period
  icr_edge_div #(
    .W(16)
  ) u_prog_div (
    .clk(clk),
    .rst_b(rst_b),
    .edge_in(ref_edge),
    .ratio(prog_ratio16),
    .div_out(prog_div_out)
  );

  icr_edge_div #(
    .W(16)
  ) u_preset_div (
    .clk(clk),
    .rst_b(rst_b),
    .edge_in(ref_edge),
    .ratio(preset_ratio),
    .div_out(preset_div_out)
  );

  // one-hot route choice; programmable path outranks the preset path
  localparam ROUTE_DIRECT = 3'b001;
  localparam ROUTE_PRESET = 3'b010;
  localparam ROUTE_PROG = 3'b100;
  reg [2:0] route_sel;

  always @* begin
    if (cfg_prog)
      route_sel = ROUTE_PROG; // R3
    else if (cfg_preset && !preset_bypass)
      route_sel = ROUTE_PRESET; // R2
    else
      route_sel = ROUTE_DIRECT; // R1
  end

  // a route change mid-period may clip one output pulse
  always @(posedge clk) begin
    if (!rst_b) begin
      dpll_clk <= 1'b0;
      monitor_clk <= 1'b0;
    end else begin
      case (route_sel)
        ROUTE_PROG: begin
          dpll_clk <= prog_div_out; // R1 R3
          monitor_clk <= prog_div_out; // R1
        end
        ROUTE_PRESET: begin
          dpll_clk <= preset_div_out; // R2
          monitor_clk <= sync2_r; // R1
        end
        default: begin
          dpll_clk <= sync2_r; // R1 R2
          monitor_clk <= sync2_r; // R1
        end
      endcase
    end
  end

  // nominal frequency decode
  always @* begin
    khz_ok = 1'b1;
    case (cfg_freq)
      `ICR_FC_8K: khz_nxt = `ICR_KHZ_8K; // R6
      `ICR_FC_T1E1: begin
        if (sonet_sdh_rate_select)
          khz_nxt = `ICR_KHZ_1544; // R7
        else
          khz_nxt = `ICR_KHZ_2048; // R7
      end
      `ICR_FC_6M48: khz_nxt = `ICR_KHZ_6M48; // R6
      `ICR_FC_19M44: khz_nxt = `ICR_KHZ_19M44; // R6
      `ICR_FC_25M92: khz_nxt = `ICR_KHZ_25M92; // R6
      `ICR_FC_38M88: khz_nxt = `ICR_KHZ_38M88; // R6
      `ICR_FC_51M84: khz_nxt = `ICR_KHZ_51M84; // R6
      `ICR_FC_77M76: khz_nxt = `ICR_KHZ_77M76; // R6
      `ICR_FC_155M52: khz_nxt = `ICR_KHZ_155M52; // R6
      `ICR_FC_2K: khz_nxt = `ICR_KHZ_2K; // R8
      `ICR_FC_4K: khz_nxt = `ICR_KHZ_4K; // R8
      default: begin
        khz_nxt = 18'h00000; // R8
        khz_ok = 1'b0;
      end
    endcase
  end

  // leaky bucket: fills on windows without edges, leaks otherwise
  assign win_end = (win_cnt_r == `ICR_ACT_WINDOW - 16'h0001);

  always @* begin
    case (cfg_prof)
      2'b00: limit_sel = bucket_limit_cfg[7:0]; // R5
      2'b01: limit_sel = bucket_limit_cfg[15:8]; // R5
      2'b10: limit_sel = bucket_limit_cfg[23:16]; // R5
      default: limit_sel = bucket_limit_cfg[31:24]; // R5
    endcase
  end

  always @* begin
    acc_nxt = acc_r;
    if (win_end) begin
      if (!edge_seen_r && !ref_edge) begin
        if (acc_r > `ICR_BUCKET_MAX - `ICR_BUCKET_STEP)
          acc_nxt = `ICR_BUCKET_MAX;
        else
          acc_nxt = acc_r + `ICR_BUCKET_STEP; // R4
      end else if (acc_r != 8'h00) begin
        acc_nxt = acc_r - 8'h01; // R4
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      win_cnt_r <= 16'h0000;
      edge_seen_r <= 1'b0;
      acc_r <= 8'h00;
    end else begin
      acc_r <= acc_nxt;
      if (win_end) begin
        win_cnt_r <= 16'h0000;
        edge_seen_r <= 1'b0;
      end else begin
        win_cnt_r <= win_cnt_r + 16'h0001;
        edge_seen_r <= edge_seen_r | ref_edge;
      end
    end
  end

  // status outputs, all registered
  always @(posedge clk) begin
    if (!rst_b) begin
      prog_div_select <= 1'b0;
      preset_eight_khz_select <= 1'b0;
      activity_profile_select <= 2'b00;
      freq_code <= 4'h1;
      nominal_khz <= 18'h00000;
      freq_code_valid <= 1'b0;
      bucket_level <= 8'h00;
      activity_alarm <= 1'b0;
    end else begin
      prog_div_select <= cfg_prog; // R11
      preset_eight_khz_select <= cfg_preset;
      activity_profile_select <= cfg_prof; // R5
      freq_code <= cfg_freq;
      nominal_khz <= khz_nxt;
      freq_code_valid <= khz_ok;
      bucket_level <= acc_r;
      // zero limit would alarm on an empty bucket; treat as disabled
      activity_alarm <= (limit_sel != 8'h00) && (acc_r >= limit_sel); // R4
    end
  end

endmodule

/* File: icr_edge_div.v */
/*
 * Edge-counting divider: produces a square level whose period is
 * ratio input edges. Assumes edge_in is a clean one-cycle pulse in
 * the clk domain and ratio is at least 2 when enabled.
 */
`timescale 1ns/1ps
module icr_edge_div #(
  parameter W = 16
) (
  input wire clk,           // system clock
  input wire rst_b,         // sync reset, active low
  input wire edge_in,       // one pulse per input edge
  input wire [W-1:0] ratio, // edges per output period
  output reg div_out        // divided level
);
  reg [W-1:0] cnt_r;
  wire [W-1:0] last = ratio - {{(W-1){1'b0}}, 1'b1};

  always @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= {W{1'b0}};
      div_out <= 1'b0;
    end else if (edge_in) begin
      // ratio shrinking mid-count must not strand the counter
      if (cnt_r >= last)
        cnt_r <= {W{1'b0}};
      else
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      div_out <= (cnt_r < (ratio >> 1));
    end
  end
endmodule

/* File: icr_map.vh */
/*
 * Register map, field positions, reset value and divide ratios for the
 * channel fourteen reference configuration block.
 * Assumes a byte-addressed Avalon-MM slave port with 32-bit words.
 */
`ifndef ICR_MAP_VH
`define ICR_MAP_VH

// printed register index and its byte address (index times four)
`define ICR_CFG_INDEX 8'h2D
`define ICR_CFG_ADDR 8'hB4
`define ICR_CFG_RESET 8'h01

// field positions
`define ICR_BIT_PROG_DIV 7
`define ICR_BIT_PRESET_8K 6
`define ICR_PROF_HI 5
`define ICR_PROF_LO 4
`define ICR_FREQ_HI 3
`define ICR_FREQ_LO 0

// frequency codes
`define ICR_FC_8K 4'h0
`define ICR_FC_T1E1 4'h1
`define ICR_FC_6M48 4'h2
`define ICR_FC_19M44 4'h3
`define ICR_FC_25M92 4'h4
`define ICR_FC_38M88 4'h5
`define ICR_FC_51M84 4'h6
`define ICR_FC_77M76 4'h7
`define ICR_FC_155M52 4'h8
`define ICR_FC_2K 4'h9
`define ICR_FC_4K 4'hA

// nominal frequencies in kHz
`define ICR_KHZ_8K 18'h00008
`define ICR_KHZ_1544 18'h00608
`define ICR_KHZ_2048 18'h00800
`define ICR_KHZ_6M48 18'h01950
`define ICR_KHZ_19M44 18'h04BF0
`define ICR_KHZ_25M92 18'h06540
`define ICR_KHZ_38M88 18'h097E0
`define ICR_KHZ_51M84 18'h0CA80
`define ICR_KHZ_77M76 18'h12FC0
`define ICR_KHZ_155M52 18'h25F80
`define ICR_KHZ_2K 18'h00002
`define ICR_KHZ_4K 18'h00004

// preset divide ratios down to 8 kHz, one edge per count
`define ICR_DIV_1544 16'h00C1
`define ICR_DIV_2048 16'h0100
`define ICR_DIV_6M48 16'h032A
`define ICR_DIV_19M44 16'h097E
`define ICR_DIV_25M92 16'h0CA8
`define ICR_DIV_38M88 16'h12FC
`define ICR_DIV_51M84 16'h1950
`define ICR_DIV_77M76 16'h25F8
`define ICR_DIV_155M52 16'h4BF0
`define ICR_DIV_BYPASS 16'h0001

// activity monitor: window in clk cycles, bucket fill per empty window
`define ICR_ACT_WINDOW 16'h0400
`define ICR_BUCKET_STEP 8'h01
`define ICR_BUCKET_MAX 8'hFF

`endif

/* File: icr_ref_src.sv */
/*
 * Reference clock source on the channel fourteen pin.
 * Assumes the bench enables it only for bursts of edges.
 */
`timescale 1ns/1ps
module icr_ref_src (
  input wire en, // run the reference
  output reg ref_out // reference pin
);
  // stands still when idle; 27 ns half period, unrelated to clk
  initial begin
    ref_out = 1'b0;
    forever begin
      #27;
      if (en)
        ref_out = ~ref_out;
    end
  end
endmodule

/* File: test_input_channel_ref_config.sv */
/*
 * Self-checking bench for the channel fourteen configuration block.
 * Assumes icr_cfg_monitor is bound and icr_ref_src drives the pin.
 */
`timescale 1ns/1ps
`include "icr_map.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  error_cnt++; $display("ERROR %s exp %0h got %0h", n, e, s); end end
module test_input_channel_ref_config;
  reg clk, rst_b, avs_read, avs_write, rate, en, dq, mq;
  reg [7:0] avs_address;
  reg [31:0] avs_writedata, rd, v, lim, l;
  reg [7:0] b;
  reg [3:0] avs_byteenable;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, pin, dpll_clk, monitor_clk, pds, p8k;
  wire [1:0] prof;
  wire [3:0] fc;
  wire [7:0] st = {pds, p8k, prof, fc};
  wire [17:0] nk;
  wire [7:0] bl;
  wire fv, al;
  wire [18:0] dk = {fv, nk};
  integer error_cnt, total_checks, seed, dcnt, mcnt, i, m, d0, m0;
  icr_ref_src src (.en(en), .ref_out(pin));
  icr_channel_cfg dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .input_channel_fourteen(pin), .sonet_sdh_rate_select(rate),
    .prog_div_ratio(14'h0004), .bucket_limit_cfg(lim),
    .dpll_clk(dpll_clk), .monitor_clk(monitor_clk),
    .prog_div_select(pds), .preset_eight_khz_select(p8k),
    .activity_profile_select(prof), .freq_code(fc), .nominal_khz(nk),
    .freq_code_valid(fv), .bucket_level(bl), .activity_alarm(al));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    dq <= dpll_clk;
    mq <= monitor_clk;
    if (dpll_clk && !dq) dcnt = dcnt + 1;
    if (monitor_clk && !mq) mcnt = mcnt + 1;
  end
  // expected {valid, kHz} for a frequency code and rate select
  function [18:0] dec(input [3:0] c, input r);
    begin
      case (c)
        `ICR_FC_8K: dec = {1'b1, `ICR_KHZ_8K};
        `ICR_FC_T1E1: dec = {1'b1, r ? `ICR_KHZ_1544 : `ICR_KHZ_2048};
        `ICR_FC_6M48: dec = {1'b1, `ICR_KHZ_6M48};
        `ICR_FC_19M44: dec = {1'b1, `ICR_KHZ_19M44};
        `ICR_FC_25M92: dec = {1'b1, `ICR_KHZ_25M92};
        `ICR_FC_38M88: dec = {1'b1, `ICR_KHZ_38M88};
        `ICR_FC_51M84: dec = {1'b1, `ICR_KHZ_51M84};
        `ICR_FC_77M76: dec = {1'b1, `ICR_KHZ_77M76};
        `ICR_FC_155M52: dec = {1'b1, `ICR_KHZ_155M52};
        `ICR_FC_2K: dec = {1'b1, `ICR_KHZ_2K};
        `ICR_FC_4K: dec = {1'b1, `ICR_KHZ_4K};
        default: dec = 19'h00000;
      endcase
    end
  endfunction
  task wrap_up;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d, input [3:0] be);
    begin
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  // counts routed edges over a burst of n reference edges
  task route(input [7:0] c, input integer n);
    begin
      bus(1, `ICR_CFG_ADDR, c, 4'hF);
      d0 = dcnt;
      m0 = mcnt;
      en <= 1'b1;
      repeat (n) @(posedge pin);
      en <= 1'b0;
      repeat (20) @(posedge clk);
      d0 = dcnt - d0;
      m0 = mcnt - m0;
    end
  endtask
  initial begin
    #400000;
    error_cnt = error_cnt + 1;
    wrap_up;
  end
  initial begin
    seed = 82334;
    error_cnt = 0;
    total_checks = 0;
    dcnt = 0;
    mcnt = 0;
    dq = 1'b0;
    mq = 1'b0;
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    rate = 1'b1;
    en = 1'b0;
    lim = 32'h00000000;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    m = `ICR_CFG_RESET;
    bus(0, `ICR_CFG_ADDR, 0, 4'hF);
    `CHK("reset", m, rd)
    // every frequency code once, random upper fields
    for (i = 0; i < 16; i = i + 1) begin
      v = ($random(seed) & 32'hFFFFFFF0) | i;
      rate <= v[8];
      bus(1, `ICR_CFG_ADDR, v, 4'h1);
      m = v[7:0];
      repeat (2) @(posedge clk);
      `CHK("status", m, st)
      `CHK("decode", dec(v[3:0], v[8]), dk)
      bus(0, `ICR_CFG_ADDR, 0, 4'hF);
      `CHK("readback", m, rd)
    end
    rate <= 1'b1;
    bus(1, 8'hB0, 32'h000000FF, 4'hF);
    bus(1, `ICR_CFG_ADDR, 32'h000000FF, 4'hE);
    bus(0, `ICR_CFG_ADDR, 0, 4'hF);
    `CHK("ignored", m, rd)
    bus(0, 8'hB0, 0, 4'hF);
    `CHK("unmapped", 0, rd)
    route(8'h01, 40);
    `CHK("mon direct", 40, m0)
    `CHK("dpll direct", 40, d0)
    route(8'h41, 386);
    `CHK("mon preset", 386, m0)
    `CHK("dpll preset", 1, (d0 >= 1 && d0 <= 3))
    route(8'hC0, 40);
    `CHK("dpll prog", m0, d0)
    `CHK("prog ratio", 1, (d0 >= 9 && d0 <= 11))
    // idle pin: one step per window; profile p picks the alarm limit
    v = $random(seed);
    bus(1, `ICR_CFG_ADDR, {26'h0, v[1:0], 4'h0}, 4'h1);
    b = bl;
    while (bl === b)
      @(posedge clk);
    b = bl;
    l = {4{b + 8'h02}};
    l[8 * v[1:0] +: 8] = b + 8'h01;
    lim <= l;
    repeat (`ICR_ACT_WINDOW - 1) @(posedge clk);
    `CHK("bucket hold", b, bl)
    `CHK("alarm low", 0, al)
    @(posedge clk);
    `CHK("bucket step", b + `ICR_BUCKET_STEP, bl)
    `CHK("alarm high", 1, al)
    `CHK("profile", v[1:0], prof)
    wrap_up;
  end
endmodule
